// File: logic/odt_ctrl.sv
/*
  On-die termination control: decides when the data, strobe and
  mask balls are terminated and at which strength.
  Assumes mode and state levels from core logic on clk_in, and
  the termination ball and write commands on the link clock ck_in.
*/
`timescale 1ns/1ps
module odt_ctrl #(
  parameter int DQ_W  = 8, // Data balls
  parameter int DQS_N = 1  // Strobe pairs, one mask each
) (
  // Core clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  // Mode register loads, core domain
  input  wire logic                    mr_load_in,
  input  wire logic [2:0]              mr1_rtt_in,
  input  wire logic [1:0]              mr2_rtt_in,
  input  wire logic [3:0]              cwl_in,
  input  wire logic [4:0]              al_in,
  input  wire logic                    tdqs_en_in,
  // Device state levels, core domain
  input  wire logic                    self_refresh_in,
  input  wire logic                    reading_in,
  input  wire logic                    dll_disable_in,
  input  wire logic                    dll_off_pd_in,
  input  wire logic                    dll_locking_in,
  // Link side
  input  wire logic                    ck_in,
  input  wire logic                    odt_in,
  input  wire logic                    wr_cmd_in,
  input  wire logic                    wr_bc4_in,
  // Termination controls
  output logic [DQ_W+3*DQS_N+1:0]      term_en_out,
  output logic [3:0]                   term_div_out,
  output logic                         write_term_out,
  output logic                         async_mode_out,
  output logic                         cfg_ready_out
);

  localparam int NB  = DQ_W + 3 * DQS_N + 2; // Terminated balls
  localparam int IDW = $clog2(odt_pkg::MAX_LAT);

  // ----------------------------------------------------------
  // Strength decoders
  // ----------------------------------------------------------
  function automatic logic [3:0] nom_div(input logic [2:0] code);
    logic [3:0] r;
    case (code)
      odt_pkg::MR1_DIV4:  r = odt_pkg::DIV4;
      odt_pkg::MR1_DIV2:  r = odt_pkg::DIV2;
      odt_pkg::MR1_DIV6:  r = odt_pkg::DIV6;
      odt_pkg::MR1_DIV12: r = odt_pkg::DIV12;
      odt_pkg::MR1_DIV8:  r = odt_pkg::DIV8;
      default:            r = odt_pkg::DIV_NONE;
    endcase
    return r;
  endfunction

  function automatic logic [3:0] wr_div(input logic [1:0] code);
    logic [3:0] r;
    case (code)
      odt_pkg::MR2_DIV4: r = odt_pkg::DIV4;
      odt_pkg::MR2_DIV2: r = odt_pkg::DIV2;
      default:           r = odt_pkg::DIV_NONE;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------
  // Core domain: mode register copy and load toggle
  // ----------------------------------------------------------
  logic [2:0] mr1_q;  // Nominal code
  logic [1:0] mr2_q;  // Write code
  logic [5:0] lat_q;  // Sync latency in link cycles
  logic       tdqs_q; // Termination strobe pair enabled
  logic       tog_q;  // Flips on every load

  wire [5:0] lat_sum = 6'(cwl_in) + 6'(al_in);
  wire       lat_low = lat_sum <= (odt_pkg::LAT_SUB + odt_pkg::LAT_MIN);
  wire       lat_big = lat_sum >= 6'(odt_pkg::MAX_LAT) + odt_pkg::LAT_SUB;
  wire [5:0] lat_d   = lat_low ? odt_pkg::LAT_MIN :
                       lat_big ? 6'(odt_pkg::MAX_LAT - 1) :
                       lat_sum - odt_pkg::LAT_SUB;

  // Capture on load; held stable while the link takes it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mr1_q  <= odt_pkg::MR1_OFF;
      mr2_q  <= odt_pkg::MR2_OFF;
      lat_q  <= odt_pkg::LAT_MIN;
      tdqs_q <= 1'b0;
      tog_q  <= 1'b0;
    end else if (mr_load_in) begin
      mr1_q  <= mr1_rtt_in;
      mr2_q  <= mr2_rtt_in;
      lat_q  <= lat_d;
      tdqs_q <= tdqs_en_in;
      tog_q  <= ~tog_q;
    end
  end

  // ----------------------------------------------------------
  // Link domain reset and crossings
  // ----------------------------------------------------------
  logic [1:0] lrst_q; // Asserted at once, released on ck_in
  wire        lrst_n = lrst_q[1];

  always_ff @(posedge ck_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lrst_q <= 2'h0;
    end else begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end

  logic [5:0] xs; // Synchronised toggle and state levels

  odt_sync3 #(
    .W (6)
  ) u_sync (
    .clk_in   (ck_in),
    .rst_n_in (lrst_n),
    .d_in     ({tog_q, self_refresh_in, reading_in, dll_disable_in, dll_off_pd_in, dll_locking_in}),
    .q_out    (xs)
  );

  wire tog_s  = xs[5];
  wire sr_s   = xs[4];
  wire rd_s   = xs[3];
  wire dis_s  = xs[2];
  wire pd_s   = xs[1];
  wire lock_s = xs[0];

  // ----------------------------------------------------------
  // Link copy of the mode registers
  // ----------------------------------------------------------
  logic       seen_q;   // Last toggle taken
  logic       cfg_ok_q; // Registers programmed since reset
  logic [2:0] l_mr1_q;
  logic [1:0] l_mr2_q;
  logic [5:0] l_lat_q;
  logic       l_tdqs_q;

  wire take = tog_s ^ seen_q;

  // Take the stable core copy once the toggle arrives
  always_ff @(posedge ck_in or negedge lrst_n) begin
    if (!lrst_n) begin
      seen_q   <= 1'b0;
      cfg_ok_q <= 1'b0;
      l_mr1_q  <= odt_pkg::MR1_OFF;
      l_mr2_q  <= odt_pkg::MR2_OFF;
      l_lat_q  <= odt_pkg::LAT_MIN;
      l_tdqs_q <= 1'b0;
    end else if (take) begin
      seen_q   <= tog_s;
      cfg_ok_q <= 1'b1;
      l_mr1_q  <= mr1_q;
      l_mr2_q  <= mr2_q;
      l_lat_q  <= lat_q;
      l_tdqs_q <= tdqs_q;
    end
  end

  // ----------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------
  wire nom_off = l_mr1_q == odt_pkg::MR1_OFF;
  wire dyn_en  = l_mr2_q != odt_pkg::MR2_OFF;
  wire ignore  = !cfg_ok_q | sr_s | dis_s | (nom_off & !dyn_en);
  wire async_r = pd_s | lock_s;
  odt_pkg::odt_mode_t mode_q; // Current form
  odt_pkg::odt_mode_t mode_d; // Next form

  // Next form of the termination path
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      odt_pkg::ST_OFF: begin
        if (!ignore) begin
          mode_d = async_r ? odt_pkg::ST_ASYNC : odt_pkg::ST_SYNC;
        end
      end
      odt_pkg::ST_SYNC: begin
        if (ignore) begin
          mode_d = odt_pkg::ST_OFF;
        end else if (async_r) begin
          mode_d = odt_pkg::ST_ASYNC;
        end
      end
      odt_pkg::ST_ASYNC: begin
        if (ignore) begin
          mode_d = odt_pkg::ST_OFF;
        end else if (!async_r) begin
          mode_d = odt_pkg::ST_SYNC;
        end
      end
      default: mode_d = odt_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge ck_in or negedge lrst_n) begin
    if (!lrst_n) begin
      mode_q <= odt_pkg::ST_OFF;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ----------------------------------------------------------
  // Registration histories in link cycles
  // ----------------------------------------------------------
  logic [odt_pkg::MAX_LAT-1:0] odt_h_q; // Ball level per edge
  logic [odt_pkg::MAX_LAT-1:0] wr_h_q;  // Write registered per edge
  logic [odt_pkg::MAX_LAT-1:0] bc4_h_q; // Chop-4 flag per edge

  // Each edge starts a fresh count for what it registers
  always_ff @(posedge ck_in or negedge lrst_n) begin
    if (!lrst_n) begin
      odt_h_q <= '0;
      wr_h_q  <= '0;
      bc4_h_q <= '0;
    end else begin
      odt_h_q <= {odt_h_q[odt_pkg::MAX_LAT-2:0], odt_in};
      wr_h_q  <= {wr_h_q[odt_pkg::MAX_LAT-2:0], wr_cmd_in};
      bc4_h_q <= {bc4_h_q[odt_pkg::MAX_LAT-2:0], wr_cmd_in & wr_bc4_in};
    end
  end

  wire [IDW-1:0] idx     = IDW'(l_lat_q - 6'h01);
  wire           odt_lat = odt_h_q[idx];
  wire           wr_hit  = wr_h_q[idx] & dyn_en & (mode_q != odt_pkg::ST_OFF);
  wire           bc4_lat = bc4_h_q[idx];

  // ----------------------------------------------------------
  // Synchronous on/off and half-cycle turn-off
  // ----------------------------------------------------------
  logic sync_q; // Termination by latency
  logic neg_q;  // Falling-edge copy, stretches turn-off

  // Ball level after the latency; read turns it off
  always_ff @(posedge ck_in or negedge lrst_n) begin
    if (!lrst_n) begin
      sync_q <= 1'b0;
    end else begin
      sync_q <= (mode_q == odt_pkg::ST_SYNC) & odt_lat & !rd_s;
    end
  end

  // Off lands half a cycle after the latency edge
  always_ff @(negedge ck_in or negedge lrst_n) begin
    if (!lrst_n) begin
      neg_q <= 1'b0;
    end else begin
      neg_q <= sync_q;
    end
  end

  // Ball drives termination directly in asynchronous form
  wire term_async = (mode_q == odt_pkg::ST_ASYNC) & odt_in & !rd_s;
  wire term_on    = sync_q | neg_q | term_async;

  // ----------------------------------------------------------
  // Write window
  // ----------------------------------------------------------
  logic       wterm_q; // Write strength in force
  logic [3:0] rem_q;   // Cycles left after this one

  // Opens at the write latency, closes 6 or 4 later
  always_ff @(posedge ck_in or negedge lrst_n) begin
    if (!lrst_n) begin
      wterm_q <= 1'b0;
      rem_q   <= 4'h0;
    end else if (wr_hit) begin
      wterm_q <= 1'b1;
      rem_q   <= (bc4_lat ? odt_pkg::BC4_WIN : odt_pkg::BL8_WIN) - 4'h1;
    end else if (rem_q != 4'h0) begin
      rem_q   <= rem_q - 4'h1;
    end else begin
      wterm_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // Strength and ball enables
  // ----------------------------------------------------------
  // Write strength replaces nominal or none; nominal otherwise
  wire [3:0] div_sel = (wterm_q & dyn_en) ? wr_div(l_mr2_q) : nom_div(l_mr1_q);
  wire       term_en = term_on & (div_sel != odt_pkg::DIV_NONE);

  assign term_div_out   = term_en ? div_sel : odt_pkg::DIV_NONE;
  assign write_term_out = wterm_q & dyn_en;
  assign async_mode_out = mode_q == odt_pkg::ST_ASYNC;
  assign cfg_ready_out  = cfg_ok_q;

  // Every ball in the group; top pair only with the strobe option
  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++) begin : g_ball
      if (gi >= NB - 2) begin : g_tdqs
        assign term_en_out[gi] = term_en & l_tdqs_q;
      end else begin : g_main
        assign term_en_out[gi] = term_en;
      end
    end
  endgenerate

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge ck_in); endclocking
  default disable iff (!lrst_n);

  sr_off_a: assert property (sr_s |-> ##3 !term_on)
    else $error("termination on in self refresh");
  dll_dis_a: assert property (dis_s |-> ##3 !term_on)
    else $error("termination on with DLL disabled");
  rst_off_a: assert property (!cfg_ok_q |-> !term_on && term_div_out == odt_pkg::DIV_NONE)
    else $error("termination before programming");
  rd_off_a: assert property (rd_s && $past(rd_s) && $past(rd_s, 2) |-> !term_on)
    else $error("termination on during read");
  async_fol_a: assert property (
    mode_q == odt_pkg::ST_ASYNC && $past(mode_q) == odt_pkg::ST_ASYNC && $past(mode_q, 2) == odt_pkg::ST_ASYNC
    && !rd_s |-> term_on == odt_in)
    else $error("async path does not follow ball");
  half_off_a: assert property ($fell(sync_q) |-> $past(neg_q) && !neg_q)
    else $error("turn-off not half a cycle late");
  bl8_win_a: assert property (wr_hit && !bc4_lat |=> wterm_q [*6])
    else $error("burst-8 write window short");
  bc4_win_a: assert property (wr_hit && bc4_lat |=> wterm_q [*4])
    else $error("chop-4 write window short");
  min_win_a: assert property ($fell(wterm_q) |-> $past(wterm_q, 4))
    else $error("write window under four cycles");
  wr_str_a: assert property (term_on && wterm_q && l_mr2_q == odt_pkg::MR2_DIV2 |-> term_div_out == odt_pkg::DIV2)
    else $error("wrong write strength");
  cov_bl8_c: cover property (wr_hit && !bc4_lat ##1 wterm_q [*6] ##1 !wterm_q);
  cov_async_c: cover property (mode_q == odt_pkg::ST_SYNC ##1 mode_q == odt_pkg::ST_ASYNC);
  cov_on_c: cover property ($rose(sync_q) && term_div_out != odt_pkg::DIV_NONE);

endmodule

// File: logic/odt_pkg.sv
/*
  Constants and types shared by the termination control block.
  Assumes it is compiled before every file that names odt_pkg.
*/
package odt_pkg;

  // ----------------------------------------------------------
  // Latency and write window figures
  // ----------------------------------------------------------
  localparam logic [5:0] LAT_SUB  = 6'h02; // Sync latency is CWL + AL minus this
  localparam logic [5:0] LAT_MIN  = 6'h01; // Shortest usable latency
  localparam int         MAX_LAT  = 32;    // Depth of the latency history
  localparam logic [3:0] BL8_WIN  = 4'h6;  // Write window after latency, burst 8
  localparam logic [3:0] BC4_WIN  = 4'h4;  // Write window after latency, chop 4

  // ----------------------------------------------------------
  // Mode register termination codes
  // ----------------------------------------------------------
  localparam logic [2:0] MR1_OFF   = 3'h0; // Nominal termination disabled
  localparam logic [2:0] MR1_DIV4  = 3'h1;
  localparam logic [2:0] MR1_DIV2  = 3'h2;
  localparam logic [2:0] MR1_DIV6  = 3'h3;
  localparam logic [2:0] MR1_DIV12 = 3'h4;
  localparam logic [2:0] MR1_DIV8  = 3'h5;
  localparam logic [1:0] MR2_OFF   = 2'h0; // Writes leave nominal in place
  localparam logic [1:0] MR2_DIV4  = 2'h1;
  localparam logic [1:0] MR2_DIV2  = 2'h2;

  // ----------------------------------------------------------
  // Strength codes: divisor of the 240 ohm reference, 0 = none
  // ----------------------------------------------------------
  localparam logic [3:0] DIV_NONE = 4'h0;
  localparam logic [3:0] DIV2     = 4'h2;
  localparam logic [3:0] DIV4     = 4'h4;
  localparam logic [3:0] DIV6     = 4'h6;
  localparam logic [3:0] DIV8     = 4'h8;
  localparam logic [3:0] DIV12    = 4'hC;

  // Operating form of the termination path
  typedef enum logic [2:0] {
    ST_OFF   = 3'b001,
    ST_SYNC  = 3'b010,
    ST_ASYNC = 3'b100
  } odt_mode_t;

endpackage

// File: logic/odt_sync3.sv
/*
  Three-stage level synchroniser; a bit changes once stages two
  and three agree. Assumes levels that stay put for several clocks.
*/
`timescale 1ns/1ps
module odt_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // Levels from the other domain
  input  wire logic [W-1:0] d_in,
  // Filtered levels
  output logic      [W-1:0] q_out
);

  logic [W-1:0] s1_q; // First stage, read only by s2_q
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_q;  // Accepted value

  // --------------------------------------------------------
  // Agreement filter
  // --------------------------------------------------------
  wire [W-1:0] agree = ~(s2_q ^ s3_q);
  wire [W-1:0] q_d   = (agree & s3_q) | (~agree & q_q);

  // Stage chain
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q_q  <= '0;
    end else begin
      s1_q <= d_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_q  <= q_d;
    end
  end

  assign q_out = q_q;

endmodule

// File: dv/odt_host.sv
/*
  Controller model: drives the termination ball and write commands.
  Assumes requests from the bench arrive on the link clock.
*/
`timescale 1ns/1ps
// ---------------------------------------------
// Ball and write driver
// ---------------------------------------------
module odt_host (
  // Link clock and reset
  input  wire logic ck_in,
  input  wire logic rst_n_in,
  // Requests from the bench
  input  wire logic on_req_in,
  input  wire logic wr_req_in,
  input  wire logic bc4_in,
  // Ball and command lines
  output logic      odt_out,
  output logic      wr_cmd_out,
  output logic      wr_bc4_out
);
  logic [2:0] hold_q; // Cycles the ball must still stay high

  // The ball never drops before its minimum high time is over
  always_ff @(posedge ck_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      odt_out    <= 1'h0;
      wr_cmd_out <= 1'h0;
      wr_bc4_out <= 1'h0;
      hold_q     <= 3'h0;
    end else begin
      wr_cmd_out <= wr_req_in;
      wr_bc4_out <= wr_req_in & bc4_in;
      if (wr_req_in) begin // Write goes out with the ball high
        odt_out <= 1'h1;
        hold_q  <= bc4_in ? 3'h3 : 3'h5;
      end else if (on_req_in && !odt_out) begin
        odt_out <= 1'h1;
        hold_q  <= 3'h3;
      end else if (hold_q != 3'h0) begin
        hold_q <= hold_q - 3'h1;
      end else if (!on_req_in) begin // Released only when asked
        odt_out <= 1'h0;
      end
    end
  end
endmodule

// File: dv/tb_odt_ctrl.sv
/*
  Self-checking bench for the termination control block.
  Assumes the controller model drives the ball on the link clock.
*/
`timescale 1ns/1ps
module tb_odt_ctrl;
  // ---------------------------------------------
  // Settings and signals
  // ---------------------------------------------
  localparam int          L  = 3;        // CWL 5 + AL 0 - 2
  localparam int          L2 = 6;        // CWL 6 + AL 2 - 2
  localparam logic [15:0] ON = 16'h1FFF; // All 13 balls terminated
  logic        clk, ck, rst_n, mr_load, tdqs_en;
  logic [2:0]  mr1, st;
  logic [3:0]  cwl;
  logic [4:0]  al;
  logic [15:0] exp_en;
  logic [1:0]  mr2, asy;
  logic        on_req, wr_req, bc4, odt, wr_cmd, wr_bc4;
  logic [12:0] term_en;
  logic [3:0]  term_div;
  logic        write_term, async_mode, cfg_ready;
  int          failures, total_checks;
  logic [3:0]  divs [0:7] = '{odt_pkg::DIV_NONE, odt_pkg::DIV4, odt_pkg::DIV2,
                              odt_pkg::DIV6, odt_pkg::DIV12, odt_pkg::DIV8,
                              odt_pkg::DIV_NONE, odt_pkg::DIV_NONE};

  initial begin clk = 1'h0; forever #50 clk = ~clk; end
  initial begin ck = 1'h0; #7; forever #24 ck = ~ck; end

  odt_ctrl dut (.clk_in(clk), .rst_n_in(rst_n), .mr_load_in(mr_load), .mr1_rtt_in(mr1),
    .mr2_rtt_in(mr2), .cwl_in(cwl), .al_in(al), .tdqs_en_in(tdqs_en),
    .self_refresh_in(st[0]), .reading_in(st[1]), .dll_disable_in(st[2]),
    .dll_off_pd_in(asy[0]), .dll_locking_in(asy[1]), .ck_in(ck), .odt_in(odt),
    .wr_cmd_in(wr_cmd), .wr_bc4_in(wr_bc4), .term_en_out(term_en), .term_div_out(term_div),
    .write_term_out(write_term), .async_mode_out(async_mode), .cfg_ready_out(cfg_ready));

  odt_host host (.ck_in(ck), .rst_n_in(rst_n), .on_req_in(on_req), .wr_req_in(wr_req),
    .bc4_in(bc4), .odt_out(odt), .wr_cmd_out(wr_cmd), .wr_bc4_out(wr_bc4));

  // ---------------------------------------------
  // Tasks
  // ---------------------------------------------
  // Compare and count
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Counts, verdict, end of run
  task summarize;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task ckw(input int n);
    repeat (n) @(posedge ck);
  endtask

  // Mode load, then room for the crossing
  task load(input logic [2:0] a, input logic [1:0] b, input logic t);
    @(posedge clk);
    mr_load <= 1'h1;
    mr1     <= a;
    mr2     <= b;
    tdqs_en <= t;
    @(posedge clk);
    mr_load <= 1'h0;
    ckw(14);
  endtask

  // Returns at the edge that sets the ball; it registers one edge later
  task ball_on;
    @(posedge ck);
    on_req <= 1'h1;
    @(posedge ck);
  endtask

  // Returns at the edge where the ball is first registered low
  task ball_off;
    @(posedge ck);
    on_req <= 1'h0;
    for (int i = 0; i < 20 && odt !== 1'h0; i++) @(posedge ck);
    if (odt !== 1'h0) begin failures++; summarize(); end
  endtask

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    failures = 0; total_checks = 0; rst_n = 1'h0; mr_load = 1'h0; mr1 = 3'h0; mr2 = 2'h0;
    st = 3'h0; asy = 2'h0; on_req = 1'h0; wr_req = 1'h0; bc4 = 1'h0; tdqs_en = 1'h1;
    cwl = 4'h5; al = 5'h00;
    repeat (20) @(posedge clk);
    chk(16'(term_en), 16'h0000);
    chk(16'(cfg_ready), 16'h0000);
    rst_n <= 1'h1;
    ball_on; ckw(L + 4); #1;
    chk(16'(term_en), 16'h0000);
    ball_off;
    load(3'h1, 2'h0, 1'h1);
    chk(16'(cfg_ready), 16'h0001);
    $display("test reset done");

    // Every nominal code, reserved ones too; code 5 with the strobe pair disabled
    for (int c = 0; c < 8; c++) begin
      exp_en = (c == 0 || c > 5) ? 16'h0000 : (c == 5 ? 16'h07FF : ON);
      load(3'(c), 2'h0, 1'(c != 5));
      ball_on; ckw(L); #1;
      chk(16'(term_en), 16'h0000);
      ckw(1); #1;
      chk(16'(term_en), exp_en);
      chk(16'(term_div), 16'(divs[c]));
      ball_off; ckw(L); #1;
      chk(16'(term_en), exp_en);
      @(negedge ck); #1;
      chk(16'(term_en), 16'h0000);
      chk(16'(term_div), 16'h0000);
    end
    $display("test nominal done");

    // Burst-8 with nominal on, then chop-4 with nominal off
    for (int p = 0; p < 2; p++) begin
      load(p == 0 ? 3'h1 : 3'h0, p == 0 ? 2'h2 : 2'h1, 1'h1);
      ball_on; ckw(6);
      @(posedge ck); wr_req <= 1'h1; bc4 <= 1'(p);
      @(posedge ck); wr_req <= 1'h0;
      ckw(L); #1;
      chk(16'(write_term), 16'h0000);
      ckw(1); #1;
      chk(16'(write_term), 16'h0001);
      chk(16'(term_div), p == 0 ? 16'h0002 : 16'h0004);
      chk(16'(term_en), ON);
      ckw(p == 0 ? 5 : 3); #1;
      chk(16'(write_term), 16'h0001);
      ckw(1); #1;
      chk(16'(write_term), 16'h0000);
      chk(16'(term_div), p == 0 ? 16'h0004 : 16'h0000);
      ball_off;
    end
    $display("test write done");

    // Self refresh, read and DLL disable each hold termination off
    load(3'h1, 2'h0, 1'h1);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk); st <= 3'(1 << i); // Ball already low
      ckw(8); ball_on; ckw(L + 4); #1;
      chk(16'(term_en), 16'h0000);
      ball_off;
      @(posedge clk); st <= 3'h0;
      ckw(8);
    end
    $display("test states done");

    // Power-down with DLL off, then DLL locking: no latency
    for (int i = 0; i < 2; i++) begin
      @(posedge clk); asy <= 2'(1 << i);
      ckw(8); #1;
      chk(16'(async_mode), 16'h0001);
      ball_on; #1;
      chk(16'(term_en), ON);
      ball_off; #1;
      chk(16'(term_en), 16'h0000);
      @(posedge clk); asy <= 2'h0;
      ckw(8); #1;
      chk(16'(async_mode), 16'h0000);
    end
    $display("test async done");

    // Longer latency from CWL 6 and AL 2
    cwl <= 4'h6;
    al  <= 5'h02;
    load(3'h2, 2'h0, 1'h1);
    ball_on; ckw(L2); #1;
    chk(16'(term_en), 16'h0000);
    ckw(1); #1;
    chk(16'(term_en), ON);
    chk(16'(term_div), 16'(odt_pkg::DIV2));
    ball_off; ckw(L2); #1;
    chk(16'(term_en), ON);
    @(negedge ck); #1;
    chk(16'(term_en), 16'h0000);
    $display("test latency done");
    summarize();
  end
endmodule
